// File: sttd_core.sv
// decoder and executor for the skip, test and flag instructions of a
// 4-bit core, with interrupt flags, a plain register port and port D
// assumes instruction words arrive at least two cycles apart
//
// Overview of operation
// - set port D bit indexed by Y
// - two-word compare with immediate, skip if equal
// - skip when accumulator equals pointed RAM nibble
// - ext0 test clears flag, skips; enabled: no-op
// - conversion test clears flag, skips; enabled: no-op
// - pin test skip level chosen by polarity bit
// - skip on power-down flag, leave it unchanged
// - serial test clears flag, skips; enabled: no-op
// - timer one test clears flag, skips; enabled: no-op
// - timer two test clears flag, skips; enabled: no-op
// - software reset resets all state but the data RAM
// - serial start clears flag, starts transfer
// - high-ref flag routes table bits into D
// - skip when selected RAM bit is zero
// - skip when carry is zero, carry kept
// - two-word port D bit test, skip on zero
`timescale 1ns/1ps
`default_nettype none
module sttd_core import sttd_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instrValid,
    input  wire logic [9:0]  instrWord,
    input  wire logic [3:0]  accValue,
    input  wire logic        carryFlag,
    input  wire logic [3:0]  yIndex,
    input  wire logic [7:0]  dataPointer,
    input  wire logic        powerDownFlag,
    input  wire logic        ramWrEn,
    input  wire logic [7:0]  ramWrAddr,
    input  wire logic [3:0]  ramWrData,
    input  wire logic        ext0Event,
    input  wire logic        convDoneEvent,
    input  wire logic        serialDoneEvent,
    input  wire logic        timerOneEvent,
    input  wire logic        timerTwoEvent,
    input  wire logic        intPin,
    input  wire logic [5:0]  portDPin,
    input  wire logic        tableRead,
    input  wire logic [1:0]  tableWordHigh,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdData,
    output var  logic [5:0]  portD,
    output var  logic        highRefEnable,
    output var  logic [1:0]  tableDLow,
    output var  logic        skipPending,
    output var  logic        skipTaken,
    output var  logic        serialStart,
    output var  logic        softResetReq,
    output var  logic        irq
);

    // device-wide reset, including the one raised by software
    logic        sysRst;
    assign sysRst = !reset_n || softResetReq;

    // pin synchronisers: bits 0..5 port D, bit 6 external pin
    logic [6:0] pinRaw;
    logic [6:0] pinMeta;
    logic [6:0] pinSync2;
    logic [6:0] pinSync3;
    logic [6:0] pinLevel;

    assign pinRaw = {intPin, portDPin};

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : gSync
            always_ff @(posedge clk) begin
                if (sysRst) begin
                    pinMeta[g]  <= 1'b0;
                    pinSync2[g] <= 1'b0;
                    pinSync3[g] <= 1'b0;
                    pinLevel[g] <= 1'b0;
                end else begin
                    pinMeta[g]  <= pinRaw[g];
                    pinSync2[g] <= pinMeta[g];
                    pinSync3[g] <= pinSync2[g];
                    if (pinSync2[g] == pinSync3[g]) begin
                        pinLevel[g] <= pinSync3[g];
                    end
                end
            end
        end
    endgenerate

    // registers written by software
    logic [3:0]           firstCtl;
    logic [3:0]           secondCtl;
    logic [3:0]           pinCtl;
    logic [NUM_FLAGS-1:0] irqMask;
    logic [NUM_FLAGS-1:0] flags;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            firstCtl  <= CTL_RESET;
            secondCtl <= CTL_RESET;
            pinCtl    <= CTL_RESET;
            irqMask   <= FLAG_RESET;
        end else if (regWr) begin
            unique case (regAddr)
                ADDR_FIRST_CTL:  firstCtl  <= regWrData[3:0];
                ADDR_SECOND_CTL: secondCtl <= regWrData[3:0];
                ADDR_PIN_CTL:    pinCtl    <= regWrData[3:0];
                ADDR_IRQ_MASK:   irqMask   <= regWrData[NUM_FLAGS-1:0];
                default: ;
            endcase
        end
    end

    // fetch and decode
    sttd_fetch_t fetchState;
    sttd_fetch_t next_fetchState;
    logic [4:0]  pendOp;
    logic [4:0]  next_pendOp;
    logic        pendSkip;
    logic        next_pendSkip;
    logic [4:0]  decOp;
    logic [3:0]  decImm;

    always_comb begin
        next_fetchState = fetchState;
        next_pendOp     = pendOp;
        next_pendSkip   = pendSkip;
        decOp           = OP_NONE;
        decImm          = instrWord[3:0];
        if (instrValid) begin
            unique case (fetchState)
                ST_ONE: begin
                    next_pendSkip = skipPending;
                    if (instrWord == OPC_ACC_EQ_IMM) begin
                        next_fetchState = ST_TWO;
                        next_pendOp     = OP_SEA;
                    end else if (instrWord == OPC_PORT_ZERO) begin
                        next_fetchState = ST_TWO;
                        next_pendOp     = OP_SZD;
                    end else if (instrWord[9:2] == OPC_BIT_ZERO_HI) begin
                        decOp = OP_SZB;
                    end else begin
                        unique case (instrWord)
                            OPC_SET_PORT_BIT: decOp = OP_SD;
                            OPC_ACC_EQ_MEM:   decOp = OP_SKIP_ACC_EQ_MEM_OP;
                            OPC_EXT0_TEST:    decOp = OP_EXT0;
                            OPC_CONV_TEST:    decOp = OP_CONV;
                            OPC_PIN_TEST:     decOp = OP_PIN;
                            OPC_PD_TEST:      decOp = OP_PD;
                            OPC_SERIAL_TEST:  decOp = OP_SER;
                            OPC_TIMER1_TEST:  decOp = OP_T1;
                            OPC_TIMER2_TEST:  decOp = OP_T2;
                            OPC_SOFT_RESET:   decOp = OP_SOFTWARE_RESET_OP;
                            OPC_SERIAL_START: decOp = OP_SST;
                            OPC_SET_HIGH_REF: decOp = OP_SET_HIGH_REF_OP;
                            OPC_CLR_HIGH_REF: decOp = OP_RUPT;
                            OPC_CARRY_ZERO:   decOp = OP_SZC;
                            default:          decOp = OP_NONE;
                        endcase
                    end
                    if (skipPending) begin
                        decOp = OP_NONE;
                    end
                end
                ST_TWO: begin
                    next_fetchState = ST_ONE;
                    next_pendSkip   = 1'b0;
                    if (pendOp == OP_SEA && instrWord[9:4] == OPC_ACC_EQ_IMM_HI) begin
                        decOp = OP_SEA;
                    end else if (pendOp == OP_SZD && instrWord == OPC_PORT_ZERO_2) begin
                        decOp = OP_SZD;
                    end
                    if (pendSkip) begin
                        decOp = OP_NONE;
                    end
                end
                default: next_fetchState = ST_ONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            fetchState <= ST_ONE;
            pendOp     <= OP_NONE;
            pendSkip   <= 1'b0;
        end else begin
            fetchState <= next_fetchState;
            pendOp     <= next_pendOp;
            pendSkip   <= next_pendSkip;
        end
    end

    // execute stage, one cycle behind the fetch so RAM data is ready
    logic [4:0] exOp;
    logic [3:0] exImm;
    logic [3:0] exAcc;
    logic       exCarry;
    logic [3:0] exY;
    logic       exPd;
    logic [3:0] ramData;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            exOp    <= OP_NONE;
            exImm   <= 4'h0;
            exAcc   <= 4'h0;
            exCarry <= 1'b0;
            exY     <= 4'h0;
            exPd    <= 1'b0;
        end else begin
            exOp    <= decOp;
            exImm   <= decImm;
            exAcc   <= accValue;
            exCarry <= carryFlag;
            exY     <= yIndex;
            exPd    <= powerDownFlag;
        end
    end

    sttd_ram uRam (
        .clk    (clk),
        .wrEn   (ramWrEn),
        .wrAddr (ramWrAddr),
        .wrData (ramWrData),
        .rdAddr (dataPointer),
        .rdData (ramData)
    );

    logic                 yOk;
    logic                 exSkip;
    logic [NUM_FLAGS-1:0] flagClr;

    assign yOk = (exY <= Y_MAX);

    always_comb begin
        exSkip  = 1'b0;
        flagClr = FLAG_RESET;
        unique case (exOp)
            OP_SEA:  exSkip = (exAcc == exImm);
            OP_SKIP_ACC_EQ_MEM_OP: exSkip = (exAcc == ramData);
            OP_EXT0: begin
                if (!firstCtl[EXT0_ENABLE_BIT]) begin
                    exSkip           = flags[ST_EXT0];
                    flagClr[ST_EXT0] = 1'b1;
                end
            end
            OP_CONV: begin
                if (!secondCtl[CONV_ENABLE_BIT]) begin
                    exSkip           = flags[ST_CONV];
                    flagClr[ST_CONV] = 1'b1;
                end
            end
            OP_PIN: begin
                if (pinCtl[PIN_POLARITY_BIT]) begin
                    exSkip = pinLevel[6];
                end else begin
                    exSkip = !pinLevel[6];
                end
            end
            OP_PD:   exSkip = exPd;
            OP_SER: begin
                if (!secondCtl[SERIAL_ENABLE_BIT]) begin
                    exSkip             = flags[ST_SERIAL];
                    flagClr[ST_SERIAL] = 1'b1;
                end
            end
            OP_T1: begin
                if (!firstCtl[TIMER_ONE_ENABLE_BIT]) begin
                    exSkip             = flags[ST_TIMER1];
                    flagClr[ST_TIMER1] = 1'b1;
                end
            end
            OP_T2: begin
                if (!firstCtl[TIMER_TWO_ENABLE_BIT]) begin
                    exSkip             = flags[ST_TIMER2];
                    flagClr[ST_TIMER2] = 1'b1;
                end
            end
            OP_SST:  flagClr[ST_SERIAL] = 1'b1;
            OP_SZB:  exSkip = !ramData[exImm[1:0]];
            OP_SZC:  exSkip = !exCarry;
            OP_SZD:  exSkip = yOk && !pinLevel[exY[2:0]];
            default: exSkip = 1'b0;
        endcase
    end

    // skip bookkeeping
    always_ff @(posedge clk) begin
        if (sysRst) begin
            skipPending <= 1'b0;
            skipTaken   <= 1'b0;
        end else begin
            skipTaken <= exSkip;
            if (exSkip) begin
                skipPending <= 1'b1;
            end else if (instrValid && fetchState == ST_ONE) begin
                skipPending <= 1'b0;
            end
        end
    end

    // request flags: an event in the clearing cycle wins
    logic [NUM_FLAGS-1:0] flagSet;
    logic [NUM_FLAGS-1:0] swClr;

    assign flagSet = {timerTwoEvent, timerOneEvent, serialDoneEvent,
                      convDoneEvent, ext0Event};
    assign swClr   = (regWr && regAddr == ADDR_IRQ_STATUS) ?
                     regWrData[NUM_FLAGS-1:0] : FLAG_RESET;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            flags <= FLAG_RESET;
        end else begin
            flags <= flagSet | (flags & ~(flagClr | swClr));
        end
    end

    logic [NUM_FLAGS-1:0] next_flagsMasked;
    assign next_flagsMasked = (flagSet | (flags & ~(flagClr | swClr))) & irqMask;

    always_ff @(posedge clk) begin
        if (sysRst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flagsMasked);
        end
    end

    // port D, high-bit reference and one-cycle requests
    always_ff @(posedge clk) begin
        if (sysRst) begin
            portD <= PORT_RESET;
        end else if (exOp == OP_SD && yOk) begin
            portD[exY[2:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            highRefEnable <= 1'b0;
        end else if (exOp == OP_SET_HIGH_REF_OP) begin
            highRefEnable <= 1'b1;
        end else if (exOp == OP_RUPT) begin
            highRefEnable <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            tableDLow <= 2'h0;
        end else if (tableRead && highRefEnable) begin
            tableDLow <= tableWordHigh;
        end
    end

    always_ff @(posedge clk) begin
        if (sysRst) begin
            serialStart <= 1'b0;
        end else begin
            serialStart <= (exOp == OP_SST);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            softResetReq <= 1'b0;
        end else begin
            softResetReq <= (exOp == OP_SOFTWARE_RESET_OP) && !softResetReq;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sysRst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_FIRST_CTL:  regRdData <= {28'h0, firstCtl};
                ADDR_SECOND_CTL: regRdData <= {28'h0, secondCtl};
                ADDR_PIN_CTL:    regRdData <= {28'h0, pinCtl};
                ADDR_IRQ_STATUS: regRdData <= {27'h0, flags};
                ADDR_IRQ_MASK:   regRdData <= {27'h0, irqMask};
                ADDR_STATE:      regRdData <= {19'h0, pinLevel[6], tableDLow,
                                               highRefEnable, skipPending, 2'h0, portD};
                default:         regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// File: sttd_pkg.sv
// constants for the skip/test instruction decoder: opcodes, register map,
// field positions and reset values
// assumes 10-bit instruction words and a 32-bit plain register port
package sttd_pkg;

    // fetch sequencer for one- and two-word instructions
    typedef enum logic [1:0] {
        ST_ONE = 2'b01,
        ST_TWO = 2'b10
    } sttd_fetch_t;

    localparam logic [9:0] OPC_SET_PORT_BIT   = 10'h015;
    localparam logic [9:0] OPC_ACC_EQ_IMM     = 10'h025;
    localparam logic [5:0] OPC_ACC_EQ_IMM_HI  = 6'h07;
    localparam logic [9:0] OPC_ACC_EQ_MEM     = 10'h026;
    localparam logic [9:0] OPC_EXT0_TEST      = 10'h038;
    localparam logic [9:0] OPC_CONV_TEST      = 10'h287;
    localparam logic [9:0] OPC_PIN_TEST       = 10'h03a;
    localparam logic [9:0] OPC_PD_TEST        = 10'h003;
    localparam logic [9:0] OPC_SERIAL_TEST    = 10'h288;
    localparam logic [9:0] OPC_TIMER1_TEST    = 10'h280;
    localparam logic [9:0] OPC_TIMER2_TEST    = 10'h281;
    localparam logic [9:0] OPC_SOFT_RESET     = 10'h001;
    localparam logic [9:0] OPC_SERIAL_START   = 10'h29e;
    localparam logic [9:0] OPC_SET_HIGH_REF   = 10'h059;
    localparam logic [9:0] OPC_CLR_HIGH_REF   = 10'h058;
    localparam logic [7:0] OPC_BIT_ZERO_HI    = 8'h08;
    localparam logic [9:0] OPC_CARRY_ZERO     = 10'h02f;
    localparam logic [9:0] OPC_PORT_ZERO      = 10'h024;
    localparam logic [9:0] OPC_PORT_ZERO_2    = 10'h02b;

    localparam logic [4:0] OP_NONE   = 5'h00;
    localparam logic [4:0] OP_SD     = 5'h01;
    localparam logic [4:0] OP_SEA    = 5'h02;
    localparam logic [4:0] OP_SKIP_ACC_EQ_MEM_OP   = 5'h03;
    localparam logic [4:0] OP_EXT0   = 5'h04;
    localparam logic [4:0] OP_CONV   = 5'h05;
    localparam logic [4:0] OP_PIN    = 5'h06;
    localparam logic [4:0] OP_PD     = 5'h07;
    localparam logic [4:0] OP_SER    = 5'h08;
    localparam logic [4:0] OP_T1     = 5'h09;
    localparam logic [4:0] OP_T2     = 5'h0a;
    localparam logic [4:0] OP_SOFTWARE_RESET_OP   = 5'h0b;
    localparam logic [4:0] OP_SST    = 5'h0c;
    localparam logic [4:0] OP_SET_HIGH_REF_OP   = 5'h0d;
    localparam logic [4:0] OP_RUPT   = 5'h0e;
    localparam logic [4:0] OP_SZB    = 5'h0f;
    localparam logic [4:0] OP_SZC    = 5'h10;
    localparam logic [4:0] OP_SZD    = 5'h11;

    localparam logic [7:0] ADDR_FIRST_CTL  = 8'h00;
    localparam logic [7:0] ADDR_SECOND_CTL = 8'h04;
    localparam logic [7:0] ADDR_PIN_CTL    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
    localparam logic [7:0] ADDR_STATE      = 8'h14;

    localparam int EXT0_ENABLE_BIT      = 0;
    localparam int TIMER_ONE_ENABLE_BIT = 2;
    localparam int TIMER_TWO_ENABLE_BIT = 3;
    localparam int CONV_ENABLE_BIT      = 2;
    localparam int SERIAL_ENABLE_BIT    = 3;
    localparam int PIN_POLARITY_BIT     = 2;

    // status bit positions (mask has the same layout)
    localparam int ST_EXT0   = 0;
    localparam int ST_CONV   = 1;
    localparam int ST_SERIAL = 2;
    localparam int ST_TIMER1 = 3;
    localparam int ST_TIMER2 = 4;
    localparam int NUM_FLAGS = 5;

    localparam int          PORT_D_BITS = 6;
    localparam logic [3:0]  Y_MAX       = 4'h5;
    localparam logic [3:0]  CTL_RESET   = 4'h0;
    localparam logic [4:0]  FLAG_RESET  = 5'h00;
    localparam logic [5:0]  PORT_RESET  = 6'h00;

endpackage

// File: sttd_ram.sv
// data memory of 256 nibbles with one write port and a registered read
// assumes a single clock; read data appear the cycle after the address
`timescale 1ns/1ps
`default_nettype none
module sttd_ram (
    input  wire logic       clk,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrAddr,
    input  wire logic [3:0] wrData,
    input  wire logic [7:0] rdAddr,
    output var  logic [3:0] rdData
);

    logic [3:0] mem [0:255];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdData <= mem[rdAddr];
    end

endmodule
`default_nettype wire

// File: sttd_core_sva.sv
// checker for the skip/test decoder: instruction effects seen at its ports
// assumes binding into sttd_core, one clock and a synchronous reset_n
`timescale 1ns/1ps
`default_nettype none
module sttd_core_chk import sttd_pkg::*; (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       instrValid,
    input  wire logic [9:0] instrWord,
    input  wire logic [3:0] yIndex,
    input  wire logic       carryFlag,
    input  wire logic       powerDownFlag,
    input  wire logic [5:0] portD,
    input  wire logic       highRefEnable,
    input  wire logic       skipPending,
    input  wire logic       skipTaken,
    input  wire logic       serialStart,
    input  wire logic       softResetReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic live;
    // a word taken while a skip is pending is swallowed
    assign live = instrValid && !skipPending;
    property p_sst; live && instrWord == OPC_SERIAL_START |-> ##2 serialStart; endproperty
    a_sst: assert property (p_sst) else $error("serial start pulse missing");
    property p_software_reset_op; live && instrWord == OPC_SOFT_RESET |-> ##2 softResetReq; endproperty
    a_software_reset_op: assert property (p_software_reset_op) else $error("soft reset request missing");
    property p_software_reset_op_clr;
        softResetReq |-> ##2 (portD == 6'h00 && !highRefEnable && !skipPending);
    endproperty
    a_software_reset_op_clr: assert property (p_software_reset_op_clr) else $error("state kept over soft reset");
    property p_set_high_ref_op; live && instrWord == OPC_SET_HIGH_REF |-> ##2 highRefEnable; endproperty
    a_set_high_ref_op: assert property (p_set_high_ref_op) else $error("high reference flag not set");
    property p_take; skipTaken |-> skipPending; endproperty
    a_take: assert property (p_take) else $error("skip without pending skip");
    property p_swallow;
        instrValid && skipPending |-> ##2 (!skipTaken && !serialStart && !softResetReq);
    endproperty
    a_swallow: assert property (p_swallow) else $error("skipped word had an effect");
    property p_sd;
        live && instrWord == OPC_SET_PORT_BIT && yIndex <= Y_MAX |-> ##2 portD[$past(yIndex, 2)];
    endproperty
    a_sd: assert property (p_sd) else $error("port bit not set");
    property p_sd_bad;
        live && instrWord == OPC_SET_PORT_BIT && yIndex > Y_MAX |-> ##2 portD == $past(portD, 2);
    endproperty
    a_sd_bad: assert property (p_sd_bad) else $error("port changed for bad index");
    property p_carry;
        live && instrWord == OPC_CARRY_ZERO |-> ##2 skipTaken == !$past(carryFlag, 2);
    endproperty
    a_carry: assert property (p_carry) else $error("carry test skip wrong");
    property p_pd;
        live && instrWord == OPC_PD_TEST |-> ##2 skipTaken == $past(powerDownFlag, 2);
    endproperty
    a_pd: assert property (p_pd) else $error("power-down test skip wrong");
    c_skip: cover property (skipTaken);
    c_sst: cover property (serialStart);
    c_software_reset_op: cover property (softResetReq);
endmodule
bind sttd_core sttd_core_chk u_sttd_core_chk (.clk(clk), .reset_n(reset_n),
    .instrValid(instrValid), .instrWord(instrWord), .yIndex(yIndex), .carryFlag(carryFlag),
    .powerDownFlag(powerDownFlag), .portD(portD), .highRefEnable(highRefEnable),
    .skipPending(skipPending), .skipTaken(skipTaken), .serialStart(serialStart),
    .softResetReq(softResetReq));
`default_nettype wire

// File: tb.sv
// self-checking bench for the skip/test instruction decoder
// assumes sttd_core with its checker bound in; every wait is a fixed count
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb import sttd_pkg::*;;
    logic clk = 0, reset_n = 0, instrValid = 0, carryFlag = 0, powerDownFlag = 0, ramWrEn = 0;
    logic intPin = 1, tableRead = 0, regWr = 0, regRd = 0;
    logic [9:0]  instrWord = 10'h000;
    logic [3:0]  accValue = 4'h0, yIndex = 4'h0, ramWrData = 4'h0;
    logic [7:0]  dataPointer = 8'h00, ramWrAddr = 8'h00, regAddr = 8'h00;
    logic [4:0]  ev = 5'h00;
    logic [5:0]  portDPin = 6'h2a;
    logic [1:0]  tableWordHigh = 2'h0;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData, rd;
    logic [5:0]  portD;
    logic [1:0]  tableDLow;
    logic        highRefEnable, skipPending, skipTaken, serialStart, softResetReq, irq;
    int          failures = 0;
    int          n_compared = 0;
    sttd_core u_sttd_core (.clk(clk), .reset_n(reset_n), .instrValid(instrValid),
        .instrWord(instrWord), .accValue(accValue), .carryFlag(carryFlag), .yIndex(yIndex),
        .dataPointer(dataPointer), .powerDownFlag(powerDownFlag), .ramWrEn(ramWrEn),
        .ramWrAddr(ramWrAddr), .ramWrData(ramWrData), .ext0Event(ev[0]),
        .convDoneEvent(ev[1]), .serialDoneEvent(ev[2]), .timerOneEvent(ev[3]),
        .timerTwoEvent(ev[4]), .intPin(intPin), .portDPin(portDPin), .tableRead(tableRead),
        .tableWordHigh(tableWordHigh), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .portD(portD),
        .highRefEnable(highRefEnable), .tableDLow(tableDLow), .skipPending(skipPending),
        .skipTaken(skipTaken), .serialStart(serialStart), .softResetReq(softResetReq),
        .irq(irq));
    initial forever #2 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic core(input logic [3:0] a, input logic c, input logic [3:0] y,
                        input logic [7:0] p, input logic d);
        @(posedge clk);
        accValue <= a;
        carryFlag <= c;
        yIndex <= y;
        dataPointer <= p;
        powerDownFlag <= d;
    endtask
    task automatic ins(input logic [9:0] word);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= word;
        @(posedge clk);
        instrValid <= 1'b0;
        step(1);
    endtask
    // a skipped word is consumed by a filler so the next test starts clean
    task automatic run(input logic [9:0] word, input logic exp);
        ins(word);
        `CHECK(skipTaken, exp)
        if (exp) ins(10'h000);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rd = regRdData;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 5'h01 << i;
        @(posedge clk);
        ev <= 5'h00;
    endtask
    task automatic t_guard();
        core(4'h0, 1'b0, 4'h0, 8'h00, 1'b0);
        run(OPC_CARRY_ZERO, 1'b1);
        `CHECK(portD, 6'h00)
    endtask
    task automatic t_port();
        logic [5:0] e;
        e = 6'h00;
        for (int y = 0; y < 7; y++) begin
            core(4'h0, 1'b1, 4'(y), 8'h00, 1'b0);
            run(OPC_SET_PORT_BIT, 1'b0);
            if (y < 6) e[y] = 1'b1;
            `CHECK(portD, e)
            ins(OPC_PORT_ZERO);
            run(OPC_PORT_ZERO_2, y < 6 && !portDPin[y]);
        end
    endtask
    task automatic t_compare();
        @(posedge clk);
        ramWrEn <= 1'b1;
        ramWrAddr <= 8'h5a;
        ramWrData <= 4'h6;
        @(posedge clk);
        ramWrEn <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            core(k[1] ? 4'hf : 4'h0, k[0], 4'h0, 8'h5a, k[1]);
            ins(OPC_ACC_EQ_IMM);
            run({OPC_ACC_EQ_IMM_HI, accValue ^ {4{k[0]}}}, !k[0]);
            run({OPC_BIT_ZERO_HI, 2'(k)}, k == 0 || k == 3);
            run(OPC_CARRY_ZERO, !k[0]);
            run(OPC_PD_TEST, k[1]);
        end
        core(4'h6, 1'b0, 4'h0, 8'h5a, 1'b0);
        run(OPC_ACC_EQ_MEM, 1'b1);
        core(4'h7, 1'b0, 4'h0, 8'h5a, 1'b0);
        run(OPC_ACC_EQ_MEM, 1'b0);
    endtask
    task automatic t_pin();
        for (int k = 0; k < 4; k++) begin
            wreg(ADDR_PIN_CTL, {29'h0, k[1], 2'h0});
            intPin <= k[0];
            step(8);
            run(OPC_PIN_TEST, k[0] == k[1]);
        end
    endtask
    task automatic t_flags();
        logic [9:0] opc [5];
        logic [7:0] ca [5];
        int         bt [5];
        opc = '{OPC_EXT0_TEST, OPC_CONV_TEST, OPC_SERIAL_TEST, OPC_TIMER1_TEST, OPC_TIMER2_TEST};
        ca = '{ADDR_FIRST_CTL, ADDR_SECOND_CTL, ADDR_SECOND_CTL, ADDR_FIRST_CTL, ADDR_FIRST_CTL};
        bt = '{EXT0_ENABLE_BIT, CONV_ENABLE_BIT, SERIAL_ENABLE_BIT, TIMER_ONE_ENABLE_BIT,
               TIMER_TWO_ENABLE_BIT};
        wreg(ADDR_IRQ_MASK, 32'h1f);
        for (int i = 0; i < 5; i++) begin
            for (int en = 0; en < 2; en++) begin
                wreg(ca[i], 32'(en) << bt[i]);
                pulse(i);
                run(opc[i], en == 0);
                rreg(ADDR_IRQ_STATUS);
                `CHECK({irq, rd[i]}, {en[0], en[0]})
                wreg(ADDR_IRQ_STATUS, 32'h1f);
            end
            wreg(ca[i], 32'h0);
        end
        wreg(ADDR_IRQ_MASK, 32'h1e);
        pulse(0);
        step(2);
        `CHECK(irq, 1'b0)
        rreg(8'hfc);
        `CHECK(rd, 32'h0)
    endtask
    task automatic t_misc();
        pulse(ST_SERIAL);
        ins(OPC_SERIAL_START);
        `CHECK(serialStart, 1'b1)
        rreg(ADDR_IRQ_STATUS);
        `CHECK(rd[ST_SERIAL], 1'b0)
        run(OPC_SET_HIGH_REF, 1'b0);
        `CHECK(highRefEnable, 1'b1)
        @(posedge clk);
        tableRead <= 1'b1;
        tableWordHigh <= 2'h2;
        @(posedge clk);
        tableRead <= 1'b0;
        step(2);
        `CHECK(tableDLow, 2'h2)
        ins(OPC_SOFT_RESET);
        `CHECK(softResetReq, 1'b1)
        step(2);
        `CHECK({portD, highRefEnable, tableDLow}, 9'h000)
    endtask
    task automatic complete_run();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        step(3);
        t_guard();
        t_port();
        t_compare();
        t_pin();
        t_flags();
        t_misc();
        complete_run();
    end
    initial begin
        #400000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
